// *** shared/pcc_pkg.sv ***
// Constants shared by the pair-join and prescaler-gating control block
// Behaviour
// - Joined pair 6/7 is one 16-bit channel on pin 7 using channel 7 settings.
// - Joined pair 4/5 is one 16-bit channel on pin 5 using channel 5 settings.
// - Joined pair 2/3 is one 16-bit channel on pin 3 using channel 3 settings.
// - Joined pair 0/1 is one 16-bit channel on pin 1 using channel 1 settings.
// - Join bits sit at control bits 7..4; clear bit means two 8-bit channels.
// - Halt-in-wait bit 3 stops prescaler clock during wait mode.
// - Halt-in-freeze bit 2 stops prescaler clock during freeze, counters hold.
// - Registers stay reachable in freeze; clearing bit or leaving freeze restarts.
// - Bits of absent channels ignore writes and read as zero.
// - Each channel picks one of four counting clock sources.
package pcc_pkg;
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 8;
  localparam int          NUM_CHAN        = 8;
  localparam int          NUM_PAIR        = 4;
  localparam int          CLK_SEL_W       = 2;
  localparam int          PRESC_W         = 8;
  localparam logic [3:0]  ADDR_CTL        = 4'h0;
  localparam logic [3:0]  ADDR_CLK_LO     = 4'h1;
  localparam logic [3:0]  ADDR_CLK_HI     = 4'h2;
  localparam logic [3:0]  ADDR_POL        = 4'h3;
  localparam logic [3:0]  ADDR_EN         = 4'h4;
  localparam logic [3:0]  ADDR_CENTER     = 4'h5;
  localparam logic [3:0]  ADDR_STATUS     = 4'h6;
  localparam logic [3:0]  ADDR_COUNT      = 4'h7;
  localparam int          BIT_JOIN67      = 7;
  localparam int          BIT_JOIN45      = 6;
  localparam int          BIT_JOIN23      = 5;
  localparam int          BIT_JOIN01      = 4;
  localparam int          BIT_HALT_WAIT   = 3;
  localparam int          BIT_HALT_FREEZE = 2;
  localparam int          JOIN_LSB        = 4;
  localparam logic [7:0]  CTL_RESET       = 8'h00;
  localparam logic [7:0]  CHAN_RESET      = 8'h00;
  localparam logic [7:0]  ZERO_BYTE       = 8'h00;
  localparam logic [7:0]  CHAN_MASK_ALL   = 8'hff;
endpackage

// *** rtl/pcc_prescaler.sv ***
// Prescaler counter that advances only while its input clock is let through
`timescale 1ns/1ps
module pcc_prescaler
  import pcc_pkg::*;
#(
  parameter int W = PRESC_W
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         run,
  output logic [W-1:0]      count
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  // Gated by enable rather than a gated clock, so no glitch on the tree
  assign count_next = run ? count_reg + {{(W-1){1'b0}}, 1'b1} : count_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;
endmodule // pcc_prescaler

// *** rtl/pcc_top.sv ***
// Pair-join mapping, clock select and prescaler gating with its register bank
`timescale 1ns/1ps
module pcc_top
  import pcc_pkg::*;
#(
  parameter logic [7:0] CHAN_MASK = CHAN_MASK_ALL
) (
  input  wire logic                          SYS_CLK,
  input  wire logic                          SRST,
  input  wire logic [ADDR_W-1:0]             ADDR,
  input  wire logic [DATA_W-1:0]             WDATA,
  input  wire logic                          WR,
  input  wire logic                          RD,
  output logic      [DATA_W-1:0]             RDATA,
  input  wire logic                          WAIT_MODE,
  input  wire logic                          FREEZE_MODE,
  output logic                               PRESCALER_CLK_EN,
  output logic      [PRESC_W-1:0]            PRESCALE_COUNT,
  output logic      [NUM_PAIR-1:0]           PAIR_JOINED,
  output logic      [NUM_CHAN*CLK_SEL_W-1:0] CHAN_CLK_SEL,
  output logic      [NUM_CHAN-1:0]           CHAN_POL,
  output logic      [NUM_CHAN-1:0]           CHAN_CENTER,
  output logic      [NUM_CHAN-1:0]           CHAN_RUN,
  output logic      [NUM_CHAN-1:0]           MODULATOR_OUTPUT_PORT_EN
);

  // A pair can join only when both of its channels exist
  localparam logic [7:0] CTL_MASK = {CHAN_MASK[7] & CHAN_MASK[6],
                                     CHAN_MASK[5] & CHAN_MASK[4],
                                     CHAN_MASK[3] & CHAN_MASK[2],
                                     CHAN_MASK[1] & CHAN_MASK[0],
                                     1'b1, 1'b1, 1'b0, 1'b0};

  // Setting source for a channel: the even half of a joined pair follows the odd half
  function automatic logic [2:0] src_chan(input logic [2:0] ch, input logic [NUM_PAIR-1:0] joined);
    src_chan = (!ch[0] && joined[ch[2:1]]) ? {ch[2:1], 1'b1} : ch;
  endfunction

  logic [7:0]                    ctl_reg;
  logic [7:0]                    clk_lo_reg;
  logic [7:0]                    clk_hi_reg;
  logic [7:0]                    pol_reg;
  logic [7:0]                    en_reg;
  logic [7:0]                    center_reg;
  logic [DATA_W-1:0]             rdata_reg;
  logic [DATA_W-1:0]             rdata_next;
  logic [NUM_CHAN*CLK_SEL_W-1:0] clk_sel_reg_all;
  logic [NUM_CHAN*CLK_SEL_W-1:0] clk_sel_next;
  logic [NUM_CHAN*CLK_SEL_W-1:0] clk_mask;
  logic [NUM_CHAN-1:0]           pol_next;
  logic [NUM_CHAN-1:0]           center_next;
  logic [NUM_CHAN-1:0]           run_next;
  logic [NUM_CHAN-1:0]           pin_next;
  logic [NUM_CHAN*CLK_SEL_W-1:0] clk_out_reg;
  logic [NUM_CHAN-1:0]           pol_out_reg;
  logic [NUM_CHAN-1:0]           center_out_reg;
  logic [NUM_CHAN-1:0]           run_out_reg;
  logic [NUM_CHAN-1:0]           pin_out_reg;
  logic [NUM_PAIR-1:0]           joined_out_reg;
  logic [NUM_PAIR-1:0]           joined;
  logic [PRESC_W-1:0]            count;
  logic [DATA_W-1:0]             status;
  logic                          wr_ctl;
  logic                          wr_clk_lo;
  logic                          wr_clk_hi;
  logic                          wr_pol;
  logic                          wr_en;
  logic                          wr_center;
  logic                          halt_wait;
  logic                          halt_freeze;
  logic                          prescaler_run;

  // Address decode
  assign wr_ctl    = WR && (ADDR == ADDR_CTL);
  assign wr_clk_lo = WR && (ADDR == ADDR_CLK_LO);
  assign wr_clk_hi = WR && (ADDR == ADDR_CLK_HI);
  assign wr_pol    = WR && (ADDR == ADDR_POL);
  assign wr_en     = WR && (ADDR == ADDR_EN);
  assign wr_center = WR && (ADDR == ADDR_CENTER);

  // Two select bits per channel, masked per channel
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_clk_mask
      assign clk_mask[gi*CLK_SEL_W +: CLK_SEL_W] = {CLK_SEL_W{CHAN_MASK[gi]}};
    end
  endgenerate

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ctl_reg <= CTL_RESET;
    end else if (wr_ctl) begin
      ctl_reg <= WDATA & CTL_MASK;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      clk_lo_reg <= CHAN_RESET;
      clk_hi_reg <= CHAN_RESET;
    end else begin
      if (wr_clk_lo) begin
        clk_lo_reg <= WDATA & clk_mask[7:0];
      end
      if (wr_clk_hi) begin
        clk_hi_reg <= WDATA & clk_mask[15:8];
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      pol_reg    <= CHAN_RESET;
      en_reg     <= CHAN_RESET;
      center_reg <= CHAN_RESET;
    end else begin
      if (wr_pol) begin
        pol_reg <= WDATA & CHAN_MASK;
      end
      if (wr_en) begin
        en_reg <= WDATA & CHAN_MASK;
      end
      if (wr_center) begin
        center_reg <= WDATA & CHAN_MASK;
      end
    end
  end

  assign clk_sel_reg_all = {clk_hi_reg, clk_lo_reg};
  assign joined          = ctl_reg[BIT_JOIN67:JOIN_LSB];
  assign halt_wait       = ctl_reg[BIT_HALT_WAIT];
  assign halt_freeze     = ctl_reg[BIT_HALT_FREEZE];

  // Combinational so a mode change gates the very same cycle
  assign prescaler_run = !(WAIT_MODE && halt_wait)
                      && !(FREEZE_MODE && halt_freeze);

  // Per-channel effective settings
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_map
      localparam logic [2:0] CH = 3'(gi);
      wire logic [2:0] src = src_chan(CH, joined);
      assign clk_sel_next[gi*CLK_SEL_W +: CLK_SEL_W] =
        clk_sel_reg_all[src*CLK_SEL_W +: CLK_SEL_W];
      assign pol_next[gi]    = pol_reg[src];
      assign center_next[gi] = center_reg[src];
      assign run_next[gi]    = en_reg[src];
      // Upper-byte half of a joined pair never drives its pin
      assign pin_next[gi]    = en_reg[gi] && (CH[0] || !joined[CH[2:1]]);
    end
  endgenerate

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      clk_out_reg    <= '0;
      pol_out_reg    <= '0;
      center_out_reg <= '0;
      run_out_reg    <= '0;
      pin_out_reg    <= '0;
      joined_out_reg <= '0;
    end else begin
      clk_out_reg    <= clk_sel_next;
      pol_out_reg    <= pol_next;
      center_out_reg <= center_next;
      run_out_reg    <= run_next;
      pin_out_reg    <= pin_next;
      joined_out_reg <= joined;
    end
  end

  pcc_prescaler #(
    .W (PRESC_W)
  ) u_prescaler (
    .clk   (SYS_CLK),
    .srst  (SRST),
    .run   (prescaler_run),
    .count (count)
  );

  // Read path is never gated by freeze, so the bank stays reachable
  assign status = {5'h00, FREEZE_MODE, WAIT_MODE, prescaler_run};

  assign rdata_next = (ADDR == ADDR_CTL)    ? ctl_reg :
                      (ADDR == ADDR_CLK_LO) ? clk_lo_reg :
                      (ADDR == ADDR_CLK_HI) ? clk_hi_reg :
                      (ADDR == ADDR_POL)    ? pol_reg :
                      (ADDR == ADDR_EN)     ? en_reg :
                      (ADDR == ADDR_CENTER) ? center_reg :
                      (ADDR == ADDR_STATUS) ? status :
                      (ADDR == ADDR_COUNT)  ? count :
                                              ZERO_BYTE;

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      rdata_reg <= ZERO_BYTE;
    end else begin
      rdata_reg <= RD ? rdata_next : ZERO_BYTE;
    end
  end

  assign RDATA                    = rdata_reg;
  assign PRESCALER_CLK_EN         = prescaler_run;
  assign PRESCALE_COUNT           = count;
  assign PAIR_JOINED              = joined_out_reg;
  assign CHAN_CLK_SEL             = clk_out_reg;
  assign CHAN_POL                 = pol_out_reg;
  assign CHAN_CENTER              = center_out_reg;
  assign CHAN_RUN                 = run_out_reg;
  assign MODULATOR_OUTPUT_PORT_EN = pin_out_reg;

  a_join67_pin_map: assert property (@(posedge SYS_CLK) disable iff (SRST)
    ctl_reg[BIT_JOIN67] |=> !MODULATOR_OUTPUT_PORT_EN[6]
      && MODULATOR_OUTPUT_PORT_EN[7] == $past(en_reg[7]) && CHAN_POL[6] == CHAN_POL[7]
      && CHAN_CENTER[6] == CHAN_CENTER[7] && CHAN_CLK_SEL[13:12] == CHAN_CLK_SEL[15:14])
    else $error("pair 6/7 join mapping wrong");

  a_join45_pin_map: assert property (@(posedge SYS_CLK) disable iff (SRST)
    ctl_reg[BIT_JOIN45] |=> !MODULATOR_OUTPUT_PORT_EN[4]
      && MODULATOR_OUTPUT_PORT_EN[5] == $past(en_reg[5]) && CHAN_POL[4] == CHAN_POL[5]
      && CHAN_RUN[4] == CHAN_RUN[5] && CHAN_CLK_SEL[9:8] == CHAN_CLK_SEL[11:10])
    else $error("pair 4/5 join mapping wrong");

  a_join23_pin_map: assert property (@(posedge SYS_CLK) disable iff (SRST)
    ctl_reg[BIT_JOIN23] |=> !MODULATOR_OUTPUT_PORT_EN[2]
      && MODULATOR_OUTPUT_PORT_EN[3] == $past(en_reg[3]) && CHAN_CENTER[2] == CHAN_CENTER[3]
      && CHAN_CLK_SEL[5:4] == CHAN_CLK_SEL[7:6])
    else $error("pair 2/3 join mapping wrong");

  a_join01_pin_map: assert property (@(posedge SYS_CLK) disable iff (SRST)
    ctl_reg[BIT_JOIN01] |=> !MODULATOR_OUTPUT_PORT_EN[0]
      && MODULATOR_OUTPUT_PORT_EN[1] == $past(en_reg[1]) && CHAN_POL[0] == CHAN_POL[1]
      && CHAN_CLK_SEL[1:0] == CHAN_CLK_SEL[3:2])
    else $error("pair 0/1 join mapping wrong");

  a_split_pair_own: assert property (@(posedge SYS_CLK) disable iff (SRST)
    !ctl_reg[BIT_JOIN01] |=> MODULATOR_OUTPUT_PORT_EN[0] == $past(en_reg[0])
      && CHAN_POL[0] == $past(pol_reg[0]) && PAIR_JOINED[0] == 1'b0)
    else $error("separate channel 0 does not use its own settings");

  // Both halves of the wait option: halted when set, running when clear
  a_wait_gate_now: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (WAIT_MODE && !FREEZE_MODE) |-> PRESCALER_CLK_EN == !ctl_reg[BIT_HALT_WAIT])
    else $error("wait gating of prescaler wrong");

  a_freeze_count_hold: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (FREEZE_MODE && ctl_reg[BIT_HALT_FREEZE]) |=> PRESCALE_COUNT == $past(PRESCALE_COUNT))
    else $error("prescaler advanced while frozen");

  a_freeze_restart: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (FREEZE_MODE && ctl_reg[BIT_HALT_FREEZE] && wr_ctl && !WDATA[BIT_HALT_FREEZE] && !WAIT_MODE)
      ##1 (FREEZE_MODE && !WAIT_MODE) |=> PRESCALE_COUNT == $past(PRESCALE_COUNT) + 8'h01)
    else $error("prescaler did not restart after halt bit cleared");

  a_freeze_reg_read: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (FREEZE_MODE && RD && ADDR == ADDR_CTL) |=> RDATA == $past(ctl_reg))
    else $error("control register unreadable in freeze");

  a_absent_reads_zero: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (RD && ADDR == ADDR_EN) |=> (RDATA & ~CHAN_MASK) == ZERO_BYTE && (ctl_reg & ~CTL_MASK) == ZERO_BYTE)
    else $error("absent channel bit read nonzero");

  a_clk_sel_own: assert property (@(posedge SYS_CLK) disable iff (SRST)
    wr_clk_hi ##1 !wr_clk_hi |=> CHAN_CLK_SEL[15:14] == $past(clk_hi_reg[7:6]))
    else $error("channel 7 clock select not applied");

endmodule // pcc_top

// *** testbench/test_pwm_channel_concat_control.sv ***
// Self-checking bench for the pair-join and prescaler-gating control block
`timescale 1ns/1ps
module test_pwm_channel_concat_control;
  import pcc_pkg::*;
  typedef struct packed {logic [7:0] wr; logic [7:0] rd; logic [3:0] joined;} pcc_row_t;
  logic                          SYS_CLK, SRST, WR, RD, WAIT_MODE, FREEZE_MODE, PRESCALER_CLK_EN;
  logic [ADDR_W-1:0]             ADDR;
  logic [DATA_W-1:0]             WDATA, RDATA, RDATA_B, v, vb, c0;
  logic [PRESC_W-1:0]            PRESCALE_COUNT;
  logic [NUM_PAIR-1:0]           PAIR_JOINED;
  logic [NUM_CHAN*CLK_SEL_W-1:0] CHAN_CLK_SEL;
  logic [NUM_CHAN-1:0]           CHAN_POL, CHAN_CENTER, CHAN_RUN, MODULATOR_OUTPUT_PORT_EN;
  logic                          en_exp;
  int                            fails, n_checks;
  pcc_row_t                      rows [7];

  pcc_top uut (.SYS_CLK(SYS_CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .WAIT_MODE(WAIT_MODE), .FREEZE_MODE(FREEZE_MODE), .PRESCALER_CLK_EN(PRESCALER_CLK_EN),
    .PRESCALE_COUNT(PRESCALE_COUNT), .PAIR_JOINED(PAIR_JOINED), .CHAN_CLK_SEL(CHAN_CLK_SEL),
    .CHAN_POL(CHAN_POL), .CHAN_CENTER(CHAN_CENTER), .CHAN_RUN(CHAN_RUN),
    .MODULATOR_OUTPUT_PORT_EN(MODULATOR_OUTPUT_PORT_EN));
  // Channels 6 and 7 absent, so their bits and the 6/7 join bit must stay zero
  pcc_top #(.CHAN_MASK(8'h3f)) uut_b (.SYS_CLK(SYS_CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA_B), .WAIT_MODE(WAIT_MODE), .FREEZE_MODE(FREEZE_MODE),
    .PRESCALER_CLK_EN(), .PRESCALE_COUNT(), .PAIR_JOINED(), .CHAN_CLK_SEL(), .CHAN_POL(),
    .CHAN_CENTER(), .CHAN_RUN(), .MODULATOR_OUTPUT_PORT_EN());

  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Bus tasks start just after an edge and return just after the taking edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1;
    v = RDATA;
    vb = RDATA_B;
  endtask

  // Even channel of a joined pair follows its odd partner
  function automatic logic [7:0] eff(input logic [7:0] r, input logic [3:0] j);
    for (int i = 0; i < 4; i++) begin
      eff[2*i+1] = r[2*i+1];
      eff[2*i] = j[i] ? r[2*i+1] : r[2*i];
    end
  endfunction

  function automatic logic [15:0] eff_clk(input logic [15:0] r, input logic [3:0] j);
    for (int i = 0; i < 4; i++) begin
      eff_clk[4*i+2 +: 2] = r[4*i+2 +: 2];
      eff_clk[4*i +: 2] = j[i] ? r[4*i+2 +: 2] : r[4*i +: 2];
    end
  endfunction

  initial begin
    #1_000_000;
    fails++;
    conclude();
  end

  initial begin
    rows = '{'{8'hff, 8'hfc, 4'hf}, '{8'h03, 8'h00, 4'h0}, '{8'h10, 8'h10, 4'h1}, '{8'h20, 8'h20, 4'h2},
             '{8'h40, 8'h40, 4'h4}, '{8'h80, 8'h80, 4'h8}, '{8'h0c, 8'h0c, 4'h0}};
    {SRST, WR, RD, WAIT_MODE, FREEZE_MODE, ADDR, WDATA} = '0;
    SRST = 1'b1;
    repeat (2) @(posedge SYS_CLK);
    #1;
    chk("reset count", PRESCALE_COUNT, 16'h0);
    chk("reset joined", PAIR_JOINED, 16'h0);
    SRST <= 1'b0;
    @(posedge SYS_CLK);
    for (int k = 0; k < 7; k++) begin
      wr(ADDR_CTL, rows[k].wr);
      rd(ADDR_CTL);
      chk("control", v, rows[k].rd);
      chk("joined", PAIR_JOINED, rows[k].joined);
    end
    $display("control table done");
    wr(ADDR_POL, 8'h55);
    wr(ADDR_EN, 8'ha6);
    wr(ADDR_CENTER, 8'h3c);
    wr(ADDR_CLK_LO, 8'he4);
    wr(ADDR_CLK_HI, 8'h1b);
    for (int j = 0; j < 16; j++) begin
      wr(ADDR_CTL, {j[3:0], 4'h0});
      @(posedge SYS_CLK);
      #1;
      chk("polarity", CHAN_POL, eff(8'h55, j[3:0]));
      chk("run", CHAN_RUN, eff(8'ha6, j[3:0]));
      chk("center", CHAN_CENTER, eff(8'h3c, j[3:0]));
      chk("pin", MODULATOR_OUTPUT_PORT_EN, 8'ha6 & ~{1'b0, j[3], 1'b0, j[2], 1'b0, j[1], 1'b0, j[0]});
      chk("clock select", CHAN_CLK_SEL, eff_clk(16'h1be4, j[3:0]));
    end
    $display("pair mapping done");
    for (int k = 0; k < 16; k++) begin
      WAIT_MODE <= k[2];
      FREEZE_MODE <= k[3];
      wr(ADDR_CTL, {4'h0, k[1], k[0], 2'b00});
      #1;
      en_exp = !(k[2] && k[1]) && !(k[3] && k[0]);
      chk("clock enable", PRESCALER_CLK_EN, en_exp);
      c0 = PRESCALE_COUNT;
      @(posedge SYS_CLK);
      #1;
      chk("count step", PRESCALE_COUNT, 8'(c0 + en_exp));
      rd(ADDR_STATUS);
      chk("status", v, {5'b0, k[3], k[2], en_exp});
    end
    FREEZE_MODE <= 1'b1;
    WAIT_MODE <= 1'b0;
    wr(ADDR_CTL, 8'h04);
    rd(ADDR_CTL);
    chk("freeze read", v, 8'h04);
    chk("freeze halt", PRESCALER_CLK_EN, 1'b0);
    wr(ADDR_CTL, 8'h00);
    #1;
    chk("freeze restart", PRESCALER_CLK_EN, 1'b1);
    c0 = PRESCALE_COUNT;
    @(posedge SYS_CLK);
    #1;
    chk("freeze run", PRESCALE_COUNT, 8'(c0 + 8'h01));
    FREEZE_MODE <= 1'b0;
    $display("gating done");
    wr(4'h6, 8'hff);
    wr(4'h7, 8'hff);
    wr(4'h9, 8'hff);
    rd(4'h9);
    chk("unmapped", v, 8'h00);
    rd(ADDR_STATUS);
    chk("status ro", v[7:1], 7'h0);
    wr(ADDR_CTL, 8'hfc);
    wr(ADDR_POL, 8'hff);
    rd(ADDR_CTL);
    chk("absent join", vb, 8'h7c);
    rd(ADDR_POL);
    chk("absent pol", vb, 8'h3f);
    chk("full pol", v, 8'hff);
    rd(ADDR_EN);
    chk("absent en", vb, 8'h26);
    @(posedge SYS_CLK);
    #1;
    chk("read idle", RDATA, 8'h00);
    $display("access limits done");
    SRST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    SRST <= 1'b0;
    #1;
    chk("rereset enable", PRESCALER_CLK_EN, 1'b1);
    chk("rereset joined", PAIR_JOINED, 16'h0);
    rd(ADDR_POL);
    chk("rereset pol", v, 8'h00);
    $display("second reset done");
    conclude();
  end
endmodule // test_pwm_channel_concat_control
